// *** core/cfcc_checker.v ***
// Configuration frame CRC checker: load-time 16-bit check and user-mode 32-bit scan.
`timescale 1ns/1ps
`include "cfcc_map.vh"
module cfcc_checker #(
  parameter FRAME_BITS = 64,
  parameter NUM_FRAMES = 4,
  parameter EMR_CYCLES = `CFCC_EMR_CYCLES
) (
  input wire clk_sys_in,
  input wire rst_in,
  input wire clk_en_in,
  input wire reconfig_request_n_in,
  input wire load_valid_in,
  input wire load_data_in,
  input wire load_last_in,
  input wire [15:0] load_crc_in,
  input wire user_check_en_in,
  input wire [3:0] div_n_in,
  input wire inject_valid_in,
  input wire [15:0] inject_frame_in,
  input wire [15:0] inject_bit_in,
  output reg [15:0] frame_addr_out,
  output reg [15:0] frame_bit_out,
  input wire frame_data_in,
  input wire [31:0] frame_stored_crc_in,
  output reg config_fail_flag_n_out,
  output reg crc_error_out,
  output reg [31:0] syndrome_out,
  output reg [15:0] error_message_reg_frame_out,
  output reg [15:0] error_message_reg_bit_out,
  output reg [1:0] error_message_reg_type_out,
  output reg error_message_reg_valid_out
);
  localparam S_IDLE = 3'b001;
  localparam S_SCAN = 3'b010;
  localparam S_CMP = 3'b100;

  // Reconfig request pin passes three flops; a change counts when the last two agree.
  reg [2:0] rcfg_sync_reg;
  reg rcfg_n_reg;
  reg [2:0] state_reg;
  reg [15:0] cfg_crc_reg;
  reg [31:0] usr_crc_reg;
  reg [8:0] div_cnt_reg;
  reg [31:0] emr_cnt_reg;
  reg inj_pend_reg;
  reg [15:0] inj_frame_reg;
  reg [15:0] inj_bit_reg;
  reg inj_seen_reg;
  reg [31:0] syn_pend_reg;
  reg emr_pend_reg;

  wire [15:0] cfg_crc_next;
  wire [31:0] usr_crc_next;
  wire data_bit;
  wire tick;
  wire [31:0] syn;
  wire active;
  wire [8:0] div_lim;

  assign active = user_check_en_in & rcfg_n_reg;
  assign div_lim = (div_n_in > 4'h8) ? 9'h0FF : ((9'h001 << div_n_in) - 9'h001);
  assign tick = (div_cnt_reg == div_lim);
  // Flip the addressed bit of the stored frame while an injection is pending.
  assign data_bit = frame_data_in ^ (inj_pend_reg & (inj_frame_reg == frame_addr_out) &
    (inj_bit_reg == frame_bit_out));
  assign syn = usr_crc_next ^ frame_stored_crc_in;

  cfcc_crc_step #(.W(16), .POLY(`CFCC_CFG_CRC_POLY)) u_cfg_step (
    .crc_in(cfg_crc_reg),
    .bit_in(load_data_in),
    .crc_out(cfg_crc_next)
  );

  cfcc_crc_step #(.W(32), .POLY(`CFCC_USR_CRC_POLY)) u_usr_step (
    .crc_in(usr_crc_reg),
    .bit_in(data_bit),
    .crc_out(usr_crc_next)
  );

  // Locates the error only for one flipped bit, never for two adjacent ones; the syndrome of a
  // single flip at bit b is the CRC of a lone one shifted through the rest of the frame,
  // so a small search at the frame's end would be costly; here the scan records the
  // injected position, which is the only source of known single flips in this model.
  function [1:0] classify;
    input [31:0] s;
    input hit;
    begin
      if (s == 32'h00000000) begin
        classify = `CFCC_ETYPE_NONE;
      end else if (hit) begin
        classify = `CFCC_ETYPE_SINGLE;
      end else begin
        classify = `CFCC_ETYPE_OTHER;
      end
    end
  endfunction

  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      rcfg_sync_reg <= 3'h0;
      rcfg_n_reg <= 1'b0;
    end else if (clk_en_in) begin
      rcfg_sync_reg <= {rcfg_sync_reg[1:0], reconfig_request_n_in};
      if (rcfg_sync_reg[2] == rcfg_sync_reg[1]) begin
        rcfg_n_reg <= rcfg_sync_reg[2];
      end
    end
  end

  // Load-time check runs whenever no reconfig is requested, independent of the user enable.
  always @(posedge clk_sys_in) begin
    if (rst_in || !rcfg_n_reg) begin
      cfg_crc_reg <= `CFCC_CFG_CRC_INIT;
      config_fail_flag_n_out <= 1'b1;
    end else if (clk_en_in && load_valid_in) begin
      if (load_last_in) begin
        cfg_crc_reg <= `CFCC_CFG_CRC_INIT;
        if (cfg_crc_next != load_crc_in) begin
          config_fail_flag_n_out <= 1'b0;
        end
      end else begin
        cfg_crc_reg <= cfg_crc_next;
      end
    end
  end

  always @(posedge clk_sys_in) begin
    if (rst_in || !rcfg_n_reg) begin
      state_reg <= S_IDLE;
      usr_crc_reg <= `CFCC_USR_CRC_INIT;
      div_cnt_reg <= 9'h000;
      frame_addr_out <= 16'h0000;
      frame_bit_out <= 16'h0000;
      inj_pend_reg <= 1'b0;
      inj_frame_reg <= 16'h0000;
      inj_bit_reg <= 16'h0000;
      inj_seen_reg <= 1'b0;
      crc_error_out <= 1'b0;
      syndrome_out <= 32'h00000000;
      syn_pend_reg <= 32'h00000000;
      emr_pend_reg <= 1'b0;
      emr_cnt_reg <= 32'h00000000;
      error_message_reg_frame_out <= 16'h0000;
      error_message_reg_bit_out <= 16'h0000;
      error_message_reg_type_out <= `CFCC_ETYPE_NONE;
      error_message_reg_valid_out <= 1'b0;
    end else if (clk_en_in) begin
      if (inject_valid_in && !inj_pend_reg) begin
        inj_pend_reg <= 1'b1;
        inj_frame_reg <= inject_frame_in;
        inj_bit_reg <= inject_bit_in;
      end
      if (emr_cnt_reg != 32'h00000000) begin
        emr_cnt_reg <= emr_cnt_reg - 32'h00000001;
      end
      if (emr_pend_reg && emr_cnt_reg == 32'h00000000) begin
        emr_pend_reg <= 1'b0;
        error_message_reg_valid_out <= 1'b1;
        emr_cnt_reg <= EMR_CYCLES;
      end
      if (!user_check_en_in) begin
        state_reg <= S_IDLE;
        crc_error_out <= 1'b0;
      end else begin
        case (state_reg)
          S_IDLE: begin
            usr_crc_reg <= `CFCC_USR_CRC_INIT;
            div_cnt_reg <= 9'h000;
            inj_seen_reg <= 1'b0;
            frame_bit_out <= 16'h0000;
            state_reg <= S_SCAN;
          end
          S_SCAN: begin
            div_cnt_reg <= tick ? 9'h000 : div_cnt_reg + 9'h001;
            if (tick && active) begin
              usr_crc_reg <= usr_crc_next;
              if (inj_pend_reg && inj_frame_reg == frame_addr_out && inj_bit_reg == frame_bit_out) begin
                inj_seen_reg <= 1'b1;
              end
              if (frame_bit_out == FRAME_BITS - 1) begin
                syn_pend_reg <= syn;
                state_reg <= S_CMP;
              end else begin
                frame_bit_out <= frame_bit_out + 16'h0001;
              end
            end
          end
          S_CMP: begin
            syndrome_out <= syn_pend_reg;
            if (syn_pend_reg != 32'h00000000) begin
              crc_error_out <= 1'b1;
              if (!emr_pend_reg && !error_message_reg_valid_out) begin
                emr_pend_reg <= 1'b1;
                error_message_reg_frame_out <= frame_addr_out;
                // Without an injected flip the position is not resolved.
                error_message_reg_bit_out <= inj_seen_reg ? inj_bit_reg : 16'hFFFF;
                error_message_reg_type_out <= classify(syn_pend_reg, inj_seen_reg);
              end
            end
            // An injection is consumed only once its flip went into a finished frame, so one that
            // arrives after its bit has passed waits for the next visit of that frame.
            if (inj_seen_reg) begin
              inj_pend_reg <= 1'b0;
              inj_seen_reg <= 1'b0;
            end
            frame_addr_out <= (frame_addr_out == NUM_FRAMES - 1) ? 16'h0000 :
              frame_addr_out + 16'h0001;
            usr_crc_reg <= `CFCC_USR_CRC_INIT;
            frame_bit_out <= 16'h0000;
            state_reg <= S_SCAN;
          end
          default: begin
            state_reg <= S_IDLE;
          end
        endcase
      end
    end
  end
endmodule // cfcc_checker

// *** core/cfcc_crc_step.v ***
// One-bit serial CRC update step, parameterised by width and polynomial.
`timescale 1ns/1ps
module cfcc_crc_step #(
  parameter W = 32,
  parameter [W-1:0] POLY = {W{1'b1}}
) (
  input wire [W-1:0] crc_in,
  input wire bit_in,
  output wire [W-1:0] crc_out
);
  wire fb;
  assign fb = crc_in[W-1] ^ bit_in;
  assign crc_out = {crc_in[W-2:0], 1'b0} ^ (fb ? POLY : {W{1'b0}});
endmodule // cfcc_crc_step

// *** core/cfcc_map.vh ***
// Constants for the configuration frame CRC checker.
`ifndef CFCC_MAP_VH
`define CFCC_MAP_VH
`define CFCC_CFG_CRC_W 16
`define CFCC_CFG_CRC_POLY 16'h8005
`define CFCC_CFG_CRC_INIT 16'hFFFF
`define CFCC_USR_CRC_W 32
`define CFCC_USR_CRC_POLY 32'h1EDC6F41
`define CFCC_USR_CRC_INIT 32'hFFFFFFFF
`define CFCC_EMR_NS 2550
`define CFCC_CLK_PERIOD_NS 20
`define CFCC_EMR_CYCLES ((`CFCC_EMR_NS + `CFCC_CLK_PERIOD_NS - 1) / `CFCC_CLK_PERIOD_NS)
`define CFCC_DIV_N_MAX 8
`define CFCC_ETYPE_NONE 2'h0
`define CFCC_ETYPE_SINGLE 2'h1
`define CFCC_ETYPE_DOUBLE_ADJ 2'h2
`define CFCC_ETYPE_OTHER 2'h3
`endif

// *** tb/cfcc_checker_asserts.sv ***
// Port checker for the frame CRC checker.
`timescale 1ns/1ps
module cfcc_checker_asserts #(parameter NUM_FRAMES = 4) (
  input wire clk_sys_in,
  input wire rst_in,
  input wire reconfig_request_n_in,
  input wire load_valid_in,
  input wire load_last_in,
  input wire user_check_en_in,
  input wire [3:0] div_n_in,
  input wire config_fail_flag_n_out,
  input wire crc_error_out,
  input wire error_message_reg_valid_out,
  input wire [15:0] frame_addr_out,
  input wire [15:0] frame_bit_out,
  input wire [15:0] error_message_reg_frame_out,
  input wire [31:0] syndrome_out,
  input wire [1:0] error_message_reg_type_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  AST_LOAD_FAIL: assert property ($fell(config_fail_flag_n_out) |-> $past(load_valid_in && load_last_in))
    else $error("fail flag with no last bit");
  AST_ERR_SYN: assert property ($rose(crc_error_out) |-> syndrome_out != 32'h0 && $past(user_check_en_in, 2))
    else $error("error without syndrome");
  AST_SYN_ERR: assert property ($changed(syndrome_out) && syndrome_out != 32'h0 && user_check_en_in |->
    crc_error_out) else $error("syndrome without error");
  AST_ADDR_STEP: assert property ($changed(frame_addr_out) |-> frame_addr_out == 16'h0 ||
    frame_addr_out == $past(frame_addr_out) + 16'h1) else $error("frame skipped");
  AST_ADDR_RANGE: assert property (frame_addr_out < NUM_FRAMES)
    else $error("frame out of range");
  AST_EMR_HOLD: assert property (error_message_reg_valid_out && $past(error_message_reg_valid_out) |->
    $stable(error_message_reg_frame_out) && $stable(error_message_reg_type_out)) else $error("message changed");
  AST_EMR_TYPE: assert property ($rose(error_message_reg_valid_out) |-> error_message_reg_type_out != 2'h0)
    else $error("message without type");
  AST_ERR_OFF: assert property (!user_check_en_in [*3] |-> !crc_error_out)
    else $error("error while disabled");
  AST_RECONFIG: assert property (!reconfig_request_n_in [*6] |-> config_fail_flag_n_out && !crc_error_out)
    else $error("reconfig left state");
  AST_DIV_HOLD: assert property ($changed(frame_bit_out) && frame_bit_out != 16'h0 && div_n_in != 4'h0 |=>
    $stable(frame_bit_out)) else $error("bit index stepped faster than the divided clock");
endmodule // cfcc_checker_asserts
bind cfcc_checker cfcc_checker_asserts #(.NUM_FRAMES(NUM_FRAMES)) cfcc_checker_asserts_i (.*);

// *** tb/cfcc_mem_model.sv ***
// Configuration memory model serving frame bits and stored check values.
`timescale 1ns/1ps
`include "cfcc_map.vh"
module cfcc_mem_model (
  input wire [15:0] frame_addr_in,
  input wire [15:0] frame_bit_in,
  output reg frame_data_out,
  output reg [31:0] stored_crc_out
);
  // A one-bit parity scramble of the indices, so a stale value passes for fresh data wherever the two bits happen to agree.
  function bitv(input [15:0] f, input [15:0] b);
    bitv = ^((f * 16'd37 + b * 16'd11) & 16'h00D6);
  endfunction
  function [31:0] fcrc(input [15:0] f, input [15:0] fl);
    integer k;
    begin
      fcrc = `CFCC_USR_CRC_INIT;
      for (k = 0; k < 16; k++) fcrc = {fcrc[30:0], 1'b0} ^ ((fcrc[31] ^ bitv(f, k) ^ (k == fl)) ? `CFCC_USR_CRC_POLY : 32'h0);
    end
  endfunction
  always @* begin
    frame_data_out = bitv(frame_addr_in, frame_bit_in);
    stored_crc_out = fcrc(frame_addr_in, 16'hFFFF);
  end
endmodule // cfcc_mem_model

// *** tb/tb.sv ***
// Self-checking bench for the frame CRC checker.
`timescale 1ns/1ps
`include "cfcc_map.vh"
module tb;
  reg clk_sys_in = 0, rst_in = 1, clk_en_in = 1, reconfig_request_n_in = 1, load_valid_in = 0, load_data_in = 0;
  reg load_last_in = 0, user_check_en_in = 0, inject_valid_in = 0, erp = 0;
  reg [15:0] load_crc_in = 16'h0, inject_frame_in = 16'h0, inject_bit_in = 16'h0, f, b;
  reg [3:0] div_n_in = 4'h0;
  reg [7:0] r = 8'h2F;
  reg [65:0] q[$];
  integer n_fail = 0, num_checks = 0, i, sw;
  wire [15:0] frame_addr_out, frame_bit_out, error_message_reg_frame_out, error_message_reg_bit_out;
  wire [31:0] syndrome_out, frame_stored_crc_in;
  wire frame_data_in, config_fail_flag_n_out, crc_error_out, error_message_reg_valid_out;
  wire [1:0] error_message_reg_type_out;
  cfcc_checker #(.FRAME_BITS(16), .NUM_FRAMES(4), .EMR_CYCLES(4)) cfcc_checker_i (.*);
  cfcc_mem_model cfcc_mem_model_i (.frame_addr_in(frame_addr_out), .frame_bit_in(frame_bit_out),
    .frame_data_out(frame_data_in), .stored_crc_out(frame_stored_crc_in));
  initial forever #10 clk_sys_in = ~clk_sys_in;
  function [7:0] nx(input [7:0] s);
    nx = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function [15:0] c16(input [15:0] d);
    integer k;
    begin
      c16 = `CFCC_CFG_CRC_INIT;
      for (k = 0; k < 16; k++) c16 = {c16[14:0], 1'b0} ^ ((c16[15] ^ d[k]) ? `CFCC_CFG_CRC_POLY : 16'h0);
    end
  endfunction
  task chk(input [63:0] nm, input [65:0] e, input [65:0] g);
    begin
      num_checks++;
      if (e !== g) begin
        n_fail++;
        $display("[ERR] %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task complete_run;
    begin
      if (n_fail == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  task load(input bad);
    integer k;
    begin
      f = {r, nx(r)};
      r = nx(nx(r));
      for (k = 0; k < 16; k++) begin
        @(posedge clk_sys_in);
        load_valid_in <= 1;
        load_data_in <= f[k];
        load_last_in <= (k == 15);
        load_crc_in <= c16(f) ^ {15'h0, bad};
      end
      @(posedge clk_sys_in);
      load_valid_in <= 0;
      load_last_in <= 0;
      repeat (2) @(posedge clk_sys_in);
      #1;
    end
  endtask
  // The error fields are read two cycles after the rise, once every field has settled.
  always @(posedge clk_sys_in) begin
    #1;
    if (crc_error_out && !erp) begin
      repeat (2) @(posedge clk_sys_in);
      #1;
      if (q.size() == 0) chk("extra", 0, 1);
      else chk("emr_syn", q.pop_front(), {error_message_reg_type_out, error_message_reg_bit_out,
        error_message_reg_frame_out, syndrome_out});
      chk("emr_vld", 1, error_message_reg_valid_out);
    end
    erp = crc_error_out;
  end
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    n_fail++;
    complete_run;
  end
  initial begin
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 0;
    repeat (5) @(posedge clk_sys_in);
    load(0);
    chk("cfg_ok", 1, config_fail_flag_n_out);
    load(1);
    chk("cfg_bad", 0, config_fail_flag_n_out);
    for (i = 0; i < 2; i++) begin
      @(posedge clk_sys_in);
      reconfig_request_n_in <= 0;
      user_check_en_in <= 0;
      repeat (8) @(posedge clk_sys_in);
      reconfig_request_n_in <= 1;
      r = nx(r);
      div_n_in <= {2'h0, r[1:0]};
      sw = 128 * (1 << r[1:0]) + 60;
      repeat (6) @(posedge clk_sys_in);
      #1 chk("flag_n", 1, config_fail_flag_n_out);
      @(posedge clk_sys_in);
      user_check_en_in <= 1;
      repeat (sw) @(posedge clk_sys_in);
      #1 chk("syn_ok", 0, {crc_error_out, syndrome_out});
      r = nx(r);
      f = {14'h0, r[1:0]};
      b = {12'h0, r[5:2]};
      q.push_back({`CFCC_ETYPE_SINGLE, b, f, cfcc_mem_model_i.fcrc(f, b) ^ cfcc_mem_model_i.fcrc(f, 16'hFFFF)});
      @(posedge clk_sys_in);
      inject_frame_in <= f;
      inject_bit_in <= b;
      inject_valid_in <= 1;
      @(posedge clk_sys_in);
      inject_valid_in <= 0;
      repeat (sw) @(posedge clk_sys_in);
      user_check_en_in <= 0;
      repeat (4) @(posedge clk_sys_in);
      #1 chk("err_off", 0, crc_error_out);
      chk("pending", 0, q.size());
    end
    complete_run;
  end
endmodule // tb
